// *** rtl/sinc_filter_pkg.sv ***
// shared constants for the sinc decimation filter
package sinc_filter_pkg;
    localparam int FILTER_ORDER               = 3;
    localparam int FILTER_OVERSAMPLING_RATIO  = 120;
    localparam int OUT_WIDTH                  = 16;
    // 120^3 = 1728000 needs 21 bits; full-range accumulator width
    localparam int ACC_WIDTH                  = 21;
    localparam int FIFO_DEPTH                 = 8;
    localparam int MOD_CLK_MAX_KHZ            = 6000;
    localparam int OUT_RATE_KHZ               = MOD_CLK_MAX_KHZ / FILTER_OVERSAMPLING_RATIO;
    localparam int CORE_CLK_MHZ               = 250;
endpackage : sinc_filter_pkg

// *** rtl/word_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } fifo_s;

    fifo_s            st_r;
    fifo_s            st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    assign in_ready  = (st_r.count != (AW+1)'(DEPTH));
    assign out_valid = (st_r.count != '0);
    assign out_data  = mem[st_r.rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wr_ptr = ptr_inc(st_r.wr_ptr);
        end
        if (pop) begin
            st_nxt.rd_ptr = ptr_inc(st_r.rd_ptr);
        end
        unique case ({push, pop})
            2'b10:   st_nxt.count = st_r.count + 1'b1;
            2'b01:   st_nxt.count = st_r.count - 1'b1;
            default: st_nxt.count = st_r.count;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_r <= '0;
            // cleared so an idle output never shows unknown data
            mem  <= '{default: '0};
        end else if (clk_en) begin
            st_r <= st_nxt;
            if (push) begin
                mem[st_r.wr_ptr] <= in_data;
            end
        end
    end
endmodule : word_fifo

// *** rtl/sinc_decimation_filter.sv ***
// third-order cic decimation filter for a 1-bit modulator stream
`timescale 1ns/1ps
// Contract
// (R1) One input bit is accepted on each modulator cycle and turned into multi-bit words; the code stops taking bits while the fifo is full.
// (R2) The filter uses only adders, subtractors and registers, with no multipliers.
// (R3) Exactly one word leaves for every 120 accepted input bits.
// (R4) Words are 16 bits, sized for a 6 MHz modulator clock giving 50 kHz words.
// (R5) Each stage sums the last N values of the stage before it, the first the last N bits.
// (R6) A stage of order k is sampled every N cycles and is meaningful after k times N bits.
// (R7) After start or reset no word is valid until order times length bits have been taken; the code gives its first word after four blocks, 480 bits.
// (R8) Once filled, a word is valid every length bits without repeating the fill delay.
// (R9) The datapath holds the full range N to the power K.
// (R10) The order is fixed at three, three integrators and three combs.
// (R11) Integrators run at input rate, decimation follows them, combs are unit differentiators.
// (R12) Synchronous reset clears all integrator, comb and counter state and the valid strobe.
// (R13) The output valid strobe is high for exactly one cycle per new word; the code holds word_valid high at the port until word_ready takes the word.
module sinc_decimation_filter
    import sinc_filter_pkg::*;
#(
    parameter int RATIO = FILTER_OVERSAMPLING_RATIO,
    parameter int OWIDTH = OUT_WIDTH,
    parameter int AWIDTH = ACC_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              bit_in,
    input  wire logic              bit_valid,
    output logic                   bit_ready,
    output logic      [OWIDTH-1:0] word_out,
    output logic                   word_valid,
    input  wire logic              word_ready
);
    // ****************************************************************
    // derived sizes
    // ****************************************************************
    // phase counts taken bits inside one decimation block
    localparam int CW = $clog2(RATIO);
    // fill counts the blocks thrown away after reset
    localparam int FW = $clog2(FILTER_ORDER + 1);
    // low bits dropped when the comb result is cut to a word
    localparam int DROP = AWIDTH - OWIDTH;
    localparam logic [CW-1:0] LAST_PHASE = CW'(RATIO - 1);
    localparam logic [FW-1:0] LAST_FILL  = FW'(FILTER_ORDER - 1);

    // latency: the integrators and combs are all registered, so the
    // comb window of the first blocks still reaches back before reset;
    // order blocks are discarded and the next one gives the first word,
    // which leaves the fifo two cycles after its last bit is taken;
    // later words follow one block apart with no new fill

    // ****************************************************************
    // state
    // ****************************************************************
    // filling until the comb windows hold only bits taken since reset
    typedef enum logic [0:0] {
        FILLING = 1'b0,
        RUNNING = 1'b1
    } mode_e;

    // all-zero is the reset image: filling, empty integrators and combs
    typedef struct packed {
        mode_e             mode;
        logic [AWIDTH-1:0] integ1;
        logic [AWIDTH-1:0] integ2;
        logic [AWIDTH-1:0] integ3;
        logic [AWIDTH-1:0] comb1_d;
        logic [AWIDTH-1:0] comb2_d;
        logic [AWIDTH-1:0] comb3_d;
        logic [CW-1:0]     phase;
        logic [FW-1:0]     fill;
        logic [OWIDTH-1:0] result;
        logic              result_valid;
    } filt_s;

    filt_s             st_r;
    filt_s             st_nxt;
    logic              take_bit;
    logic              block_end;
    logic              fill_done;
    logic              fifo_ready;
    logic [CW-1:0]     phase_next;
    logic [AWIDTH-1:0] integ1_sum;
    logic [AWIDTH-1:0] integ2_sum;
    logic [AWIDTH-1:0] integ3_sum;
    logic [AWIDTH-1:0] c1;
    logic [AWIDTH-1:0] c2;
    logic [AWIDTH-1:0] c3;
    logic [OWIDTH-1:0] word_nxt;

    // ****************************************************************
    // arithmetic
    // ****************************************************************
    // integrators wrap modulo 2^AWIDTH; the combs undo the wrap exactly
    function automatic logic [AWIDTH-1:0] integ_add(
        input logic [AWIDTH-1:0] acc,
        input logic [AWIDTH-1:0] inc
    );
        integ_add = acc + inc;
    endfunction : integ_add

    // unit-delay differentiator at the decimated rate
    function automatic logic [AWIDTH-1:0] comb_diff(
        input logic [AWIDTH-1:0] cur,
        input logic [AWIDTH-1:0] prev
    );
        comb_diff = cur - prev;
    endfunction : comb_diff

    // truncation, not rounding: full scale still fits the word
    function automatic logic [OWIDTH-1:0] scale_out(input logic [AWIDTH-1:0] v);
        scale_out = v[DROP +: OWIDTH];
    endfunction : scale_out

    // wraps after the last bit of a block
    function automatic logic [CW-1:0] phase_step(input logic [CW-1:0] p);
        if (p == LAST_PHASE) begin
            phase_step = '0;
        end else begin
            phase_step = p + 1'b1;
        end
    endfunction : phase_step

    // ****************************************************************
    // bit intake
    // ****************************************************************
    // bits are taken only when the word path has room, so no word is dropped
    assign bit_ready  = fifo_ready;
    assign take_bit   = bit_valid & fifo_ready; // R1
    // the last bit of a block closes it and drives the combs
    assign block_end  = take_bit & (st_r.phase == LAST_PHASE); // R3
    assign phase_next = phase_step(st_r.phase);
    // the last discarded block switches the filter to running
    assign fill_done  = (st_r.fill == LAST_FILL);

    // ****************************************************************
    // integrators, input rate
    // ****************************************************************
    // each later stage adds the registered value of the stage before it; the first adds bit_in
    assign integ1_sum = integ_add(st_r.integ1, AWIDTH'(bit_in)); // R5 R2
    assign integ2_sum = integ_add(st_r.integ2, st_r.integ1); // R10
    assign integ3_sum = integ_add(st_r.integ3, st_r.integ2); // R9

    // ****************************************************************
    // combs, decimated rate
    // ****************************************************************
    // decimation happens here: the last integrator is read once a block
    assign c1       = comb_diff(st_r.integ3, st_r.comb1_d); // R11
    assign c2       = comb_diff(c1, st_r.comb2_d);
    assign c3       = comb_diff(c2, st_r.comb3_d);
    assign word_nxt = scale_out(c3); // R4

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_nxt              = st_r;
        // the strobe lives one enabled cycle; blocks are never back to back
        st_nxt.result_valid = 1'b0; // R13
        if (take_bit) begin
            st_nxt.integ1 = integ1_sum;
            st_nxt.integ2 = integ2_sum;
            st_nxt.integ3 = integ3_sum;
            st_nxt.phase  = phase_next;
        end
        if (block_end) begin
            st_nxt.comb1_d = st_r.integ3; // R11
            st_nxt.comb2_d = c1;
            st_nxt.comb3_d = c2;
            st_nxt.result  = word_nxt;
            unique case (st_r.mode)
                FILLING: begin
                    if (fill_done) begin
                        st_nxt.mode = RUNNING; // R7
                    end else begin
                        st_nxt.fill = st_r.fill + 1'b1; // R6
                    end
                end
                RUNNING: begin
                    st_nxt.result_valid = 1'b1; // R8
                end
            endcase
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // reset wins over a low enable so a frozen filter can still restart;
    // a low enable holds every register, the pending strobe included
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_r <= '0; // R12
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // output buffer
    // ****************************************************************
    // eight words ride out a slow consumer; past that the intake stalls
    // rather than dropping a finished word
    word_fifo #(
        .WIDTH (OWIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .in_data   (st_r.result),
        .in_valid  (st_r.result_valid),
        .in_ready  (fifo_ready),
        .out_data  (word_out),
        .out_valid (word_valid),
        .out_ready (word_ready)
    );
endmodule : sinc_decimation_filter

// *** verification/sinc_props.sv ***
// port checker for the sinc decimation filter
`timescale 1ns/1ps
module sinc_props #(parameter int RATIO = 120, parameter int OWIDTH = 16) (
    input wire logic              core_clk,
    input wire logic              reset_n,
    input wire logic              clk_en,
    input wire logic              bit_in,
    input wire logic              bit_valid,
    input wire logic              bit_ready,
    input wire logic [OWIDTH-1:0] word_out,
    input wire logic              word_valid,
    input wire logic              word_ready
);
    int   taken_r, pops_r;
    logic take, pop;
    assign take = clk_en & bit_valid & bit_ready;
    assign pop  = clk_en & word_valid & word_ready;
    always_ff @(posedge core_clk) begin
        taken_r <= reset_n ? taken_r + take : 0;
        pops_r  <= reset_n ? pops_r + pop : 0;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_rst_idle: assert property (disable iff (1'b0) !reset_n |=> !word_valid && bit_ready)
        else $error("not idle");
    a_fill_wait: assert property (word_valid |-> taken_r >= 4 * RATIO) else $error("early");
    a_first_word: assert property (take && taken_r == 4 * RATIO - 1 ##1 clk_en |=> word_valid)
        else $error("late");
    a_word_rate: assert property (pop |-> (pops_r + 4) * RATIO <= taken_r) else $error("fast");
    a_word_hold: assert property (word_valid && !pop |=> word_valid && $stable(word_out))
        else $error("lost");
    a_full_data: assert property (!bit_ready |-> word_valid) else $error("full");
    a_empty_room: assert property (!word_valid |-> bit_ready) else $error("stall");
    a_freeze_en: assert property (!clk_en |=> $stable({word_valid, bit_ready, word_out}))
        else $error("moved");
    c_pop: cover property (pop);
    c_full: cover property (!bit_ready);
    c_gap: cover property (!clk_en ##1 word_valid);
endmodule : sinc_props
bind sinc_decimation_filter sinc_props #(.RATIO(RATIO), .OWIDTH(OWIDTH)) props (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .bit_in(bit_in),
    .bit_valid(bit_valid), .bit_ready(bit_ready), .word_out(word_out),
    .word_valid(word_valid), .word_ready(word_ready));

// *** verification/bit_source.sv ***
// modulator model: density-coded bit stream with valid/ready
`timescale 1ns/1ps
module bit_source (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    input  wire logic       bit_ready,
    input  wire logic       run,
    input  wire logic       slow,
    input  wire logic [8:0] level,
    output logic            bit_in,
    output logic            bit_valid
);
    logic [8:0] acc;
    logic       took, skip;
    always @(posedge core_clk) took <= bit_valid & bit_ready & clk_en;
    // a bit is held until taken; idle data toggles so it is never stale
    always @(negedge core_clk) begin
        if (!reset_n) {acc, bit_valid, skip} = '0;
        else if (took || !bit_valid) begin
            skip = slow & ~skip;
            bit_valid = run & ~skip;
            acc = bit_valid ? acc + level : acc;
            bit_in = bit_valid ? acc[8] : ~bit_in;
            acc[8] = 1'b0;
        end
    end
endmodule : bit_source

// *** verification/testbench.sv ***
// self-checking bench for the sinc decimation filter
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
    import sinc_filter_pkg::*;
    localparam int FULL = (FILTER_OVERSAMPLING_RATIO ** FILTER_ORDER) >> (ACC_WIDTH - OUT_WIDTH);
    logic        core_clk, reset_n, clk_en, gate, word_ready, run, slow;
    logic        bit_in, bit_valid, bit_ready, word_valid;
    logic [8:0]  level;
    logic [15:0] word_out;
    int          errors, compares;
    sinc_decimation_filter uut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
        .bit_in(bit_in), .bit_valid(bit_valid), .bit_ready(bit_ready), .word_out(word_out),
        .word_valid(word_valid), .word_ready(word_ready));
    bit_source src (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .run(run),
        .bit_ready(bit_ready), .slow(slow), .level(level), .bit_in(bit_in),
        .bit_valid(bit_valid));
    initial begin
        core_clk = 0;
        forever #2 core_clk = ~core_clk;
    end
    always @(negedge core_clk) clk_en <= gate ? ~clk_en : 1'b1;
    task automatic end_of_test();
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic wait_on(input bit full);
        for (int n = 0; full ? bit_ready !== 1'b0 : word_valid !== 1'b1; n++) begin
            if (n > 9000) begin
                errors++;
                end_of_test();
            end
            @(negedge core_clk);
        end
    endtask : wait_on
    task automatic restart(input logic [8:0] lv, input logic sl);
        reset_n = 0;
        {level, slow, run} = {lv, sl, 1'b1};
        repeat (6) @(negedge core_clk);
        reset_n = 1;
        `CHK({word_valid, bit_ready}, 2'b01)
    endtask : restart
    task automatic take_word(input logic [15:0] exp);
        wait_on(1'b0);
        `CHK(word_out, exp)
        // with a gated enable the pop waits for an enabled edge
        @(posedge core_clk);
        if (!clk_en) @(posedge core_clk);
        @(negedge core_clk);
    endtask : take_word
    // gated enable on the mid level shows the pipeline freezes rather than slips
    task automatic t_levels();
        logic [8:0] lv[3] = '{9'h000, 9'h080, 9'h100};
        for (int i = 0; i < 3; i++) begin
            gate = (i == 1);
            restart(lv[i], 1'b0);
            repeat (3) take_word(16'(FULL * lv[i] / 256));
        end
        gate = 0;
    endtask : t_levels
    task automatic t_stall();
        word_ready = 0;
        restart(9'h100, 1'b1);
        wait_on(1'b1);
        run = 0;
        repeat (8) @(negedge core_clk);
        `CHK(bit_ready, 1'b0)
        word_ready = 1;
        repeat (FIFO_DEPTH) take_word(16'(FULL));
        `CHK(word_valid, 1'b0)
    endtask : t_stall
    initial begin
        {reset_n, clk_en, gate, word_ready, run, slow, level} = {6'b010100, 9'h000};
        errors = 0;
        compares = 0;
        t_levels();
        t_stall();
        end_of_test();
    end
endmodule : testbench
